// ===== logic/i2c_status_flag_logic.sv
// Status-flag logic of an I2C controller, with link watcher and register port
// Operation
// - Set collision flag on master bus collision
// - General call sets flag, Stop clears
// - Ten-bit second byte match sets flag
// - Busy transmit write rejected, sets write-collision
// - New byte over unread buffer sets overflow
// - Overflow set at transfer; software clears
// - Data/address flag shows last byte kind
// - Address match clears, data byte sets
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`include "i2c_flags_cfg.svh"

module i2c_status_flag_logic
  import i2c_flags_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [`ADDR_W-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_master_active,
  input wire logic i_master_sda_out,
  output logic o_irq,
  output logic [7:0] o_tx_data,
  output logic o_tx_load
);

  // ****************************************
  // Link input synchronisers
  // ****************************************
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_r;
  logic sda_r;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], i_scl};
      sda_sync_r <= {sda_sync_r[0], i_sda};
      scl_r <= scl_sync_r[1];
      sda_r <= sda_sync_r[1];
    end
  end

  wire logic scl_s = scl_sync_r[1];
  wire logic sda_s = sda_sync_r[1];
  wire logic scl_rise = scl_s & ~scl_r;
  wire logic scl_fall = ~scl_s & scl_r;
  wire logic start_det = scl_s & scl_r & sda_r & ~sda_s;
  wire logic stop_det = scl_s & scl_r & ~sda_r & sda_s;

  // ****************************************
  // Software registers
  // ****************************************
  logic [9:0] own_addr_r;
  logic ten_mode_r;
  logic [`IRQ_W-1:0] irq_mask_r;
  logic [`IRQ_W-1:0] irq_stat_r;
  logic [7:0] rx_buffer_reg_r;
  logic rx_full_r;
  logic [7:0] tx_buffer_reg_r;
  logic tx_load_r;
  logic busy_r;

  wire logic wr_status = i_wr && (i_addr == `OFF_STATUS);
  wire logic wr_tx = i_wr && (i_addr == `OFF_TX_BUF);
  wire logic rd_rx = i_rd && (i_addr == `OFF_RX_BUF);

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      own_addr_r <= `RST_OWN_ADDR;
      ten_mode_r <= 1'b0;
      irq_mask_r <= '0;
    end else if (i_wr && i_addr == `OFF_CTRL) begin
      ten_mode_r <= i_wdata[0];
    end else if (i_wr && i_addr == `OFF_OWN_ADDR) begin
      own_addr_r <= i_wdata[9:0];
    end else if (i_wr && i_addr == `OFF_IRQ_MASK) begin
      irq_mask_r <= i_wdata[`IRQ_W-1:0];
    end
  end

  // ****************************************
  // Receive walker
  // ****************************************
  link_state_t state_r;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic byte_done;
  logic addressed_r;
  logic ten_pending_r;

  assign byte_done = scl_fall && bit_cnt_r == 4'h8;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      shift_r <= 8'h00;
      bit_cnt_r <= 4'h0;
    end else if (start_det || stop_det) begin
      bit_cnt_r <= 4'h0;
    end else if (scl_rise && bit_cnt_r < 4'h8) begin
      shift_r <= {shift_r[6:0], sda_s};
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end else if (scl_fall && bit_cnt_r == 4'h8) begin
      bit_cnt_r <= 4'h9;
    end else if (scl_fall && bit_cnt_r == 4'h9) begin
      bit_cnt_r <= 4'h0;
    end
  end

  // Event strobes from completed bytes
  logic ev_addr_match;
  logic ev_gcall;
  logic ev_ten;
  logic ev_data;

  always_comb begin
    ev_addr_match = 1'b0;
    ev_gcall = 1'b0;
    ev_ten = 1'b0;
    ev_data = 1'b0;
    if (byte_done) begin
      unique case (state_r)
        ST_ADDR: begin
          if (shift_r == `GCALL_ADDR) begin
            ev_gcall = 1'b1;
            ev_addr_match = 1'b1;
          end else if (!ten_mode_r && shift_r[7:1] == own_addr_r[6:0]) begin
            ev_addr_match = 1'b1;
          end
        end
        ST_ADDR2: begin
          if (shift_r == own_addr_r[7:0]) begin
            ev_ten = 1'b1;
            ev_addr_match = 1'b1;
          end
        end
        ST_DATA: ev_data = addressed_r;
        ST_IDLE, ST_ACK, ST_SKIP: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_r <= ST_IDLE;
      addressed_r <= 1'b0;
      ten_pending_r <= 1'b0;
    end else if (stop_det) begin
      state_r <= ST_IDLE;
      addressed_r <= 1'b0;
      ten_pending_r <= 1'b0;
    end else if (start_det) begin
      state_r <= ST_ADDR;
    end else if (byte_done) begin
      unique case (state_r)
        ST_ADDR: begin
          if (ev_addr_match) begin
            addressed_r <= 1'b1;
            state_r <= ST_DATA;
          end else if (ten_mode_r && shift_r[7:3] == `TEN_HDR && shift_r[2:1] == own_addr_r[9:8]) begin
            // Repeated start read after a ten-bit match keeps the match
            addressed_r <= ten_pending_r && shift_r[0];
            state_r <= shift_r[0] ? ST_DATA : ST_ADDR2;
          end else begin
            state_r <= ST_SKIP;
          end
        end
        ST_ADDR2: begin
          addressed_r <= ev_ten;
          ten_pending_r <= ev_ten;
          state_r <= ev_ten ? ST_DATA : ST_SKIP;
        end
        ST_DATA, ST_ACK, ST_SKIP, ST_IDLE: ;
      endcase
    end
  end

  // ****************************************
  // Receive buffer and overflow
  // ****************************************
  wire logic rx_xfer = ev_data;
  logic ev_rov;
  assign ev_rov = rx_xfer && rx_full_r && !rd_rx;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rx_buffer_reg_r <= 8'h00;
      rx_full_r <= 1'b0;
    end else begin
      if (rx_xfer && !ev_rov) begin
        rx_buffer_reg_r <= shift_r;
        rx_full_r <= 1'b1;
      end else if (rd_rx) begin
        rx_full_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Transmit buffer and busy
  // ****************************************
  logic ev_wcol;
  assign ev_wcol = wr_tx && busy_r;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      busy_r <= 1'b0;
    end else if (stop_det) begin
      busy_r <= 1'b0;
    end else if (start_det) begin
      busy_r <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      tx_buffer_reg_r <= 8'h00;
      tx_load_r <= 1'b0;
    end else begin
      tx_load_r <= wr_tx && !busy_r;
      if (wr_tx && !busy_r) begin
        tx_buffer_reg_r <= i_wdata[7:0];
      end
    end
  end

  // Collision: driving high but line seen low at the SCL rising edge
  wire logic ev_coll = i_master_active && scl_rise && i_master_sda_out && !sda_s;

  // ****************************************
  // Status flags
  // ****************************************
  status_flags_t flags;
  logic coll_r, gcall_r, ten_r, wcol_r, rov_r, da_r, stop_r;
  assign flags = {coll_r, gcall_r, ten_r, wcol_r, rov_r, da_r, stop_r};

  // Software clears by writing one; a same-cycle event wins
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      coll_r <= 1'b0;
      wcol_r <= 1'b0;
      rov_r <= 1'b0;
    end else begin
      if (ev_coll) begin
        coll_r <= 1'b1;
      end else if (wr_status && i_wdata[`BIT_COLL]) begin
        coll_r <= 1'b0;
      end
      if (ev_wcol) begin
        wcol_r <= 1'b1;
      end else if (wr_status && i_wdata[`BIT_WCOL]) begin
        wcol_r <= 1'b0;
      end
      if (ev_rov) begin
        rov_r <= 1'b1;
      end else if (wr_status && i_wdata[`BIT_ROV]) begin
        rov_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      gcall_r <= 1'b0;
      ten_r <= 1'b0;
    end else if (stop_det) begin
      gcall_r <= 1'b0;
      ten_r <= 1'b0;
    end else begin
      if (ev_gcall) begin
        gcall_r <= 1'b1;
      end
      if (ev_ten) begin
        ten_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      da_r <= 1'b0;
    end else if (ev_addr_match) begin
      da_r <= 1'b0;
    end else if (ev_data) begin
      da_r <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      stop_r <= 1'b0;
    end else if (stop_det) begin
      stop_r <= 1'b1;
    end else if (start_det) begin
      stop_r <= 1'b0;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic [`IRQ_W-1:0] irq_ev;
  assign irq_ev = {stop_det, ev_rov, ev_wcol, ev_coll};

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      irq_stat_r <= '0;
    end else if (i_wr && i_addr == `OFF_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~i_wdata[`IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_r <= irq_stat_r | irq_ev;
    end
  end

  assign o_irq = |(irq_stat_r & irq_mask_r);
  assign o_tx_data = tx_buffer_reg_r;
  assign o_tx_load = tx_load_r;

  // ****************************************
  // Read port
  // ****************************************
  logic [15:0] status_word;
  always_comb begin
    status_word = `RST_STATUS;
    status_word[`BIT_COLL] = flags.coll;
    status_word[`BIT_GCALL] = flags.gcall;
    status_word[`BIT_TEN] = flags.ten;
    status_word[`BIT_WCOL] = flags.wcol;
    status_word[`BIT_ROV] = flags.rov;
    status_word[`BIT_DA] = flags.da;
    status_word[`BIT_STOP] = flags.stop;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      unique case (i_addr)
        `OFF_STATUS: o_rdata <= status_word;
        `OFF_CTRL: o_rdata <= {15'h0000, ten_mode_r};
        `OFF_OWN_ADDR: o_rdata <= {6'h00, own_addr_r};
        `OFF_TX_BUF: o_rdata <= {8'h00, tx_buffer_reg_r};
        `OFF_RX_BUF: o_rdata <= {8'h00, rx_buffer_reg_r};
        `OFF_IRQ_STAT: o_rdata <= {12'h000, irq_stat_r};
        `OFF_IRQ_MASK: o_rdata <= {12'h000, irq_mask_r};
        default: o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

endmodule

// ===== shared/i2c_flags_cfg.svh
// Offsets, field positions, reset values and bus constants of the status-flag block
`ifndef I2C_FLAGS_CFG_SVH
`define I2C_FLAGS_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_W 4
`define OFF_STATUS 4'h0
`define OFF_CTRL 4'h1
`define OFF_OWN_ADDR 4'h2
`define OFF_TX_BUF 4'h3
`define OFF_RX_BUF 4'h4
`define OFF_IRQ_STAT 4'h5
`define OFF_IRQ_MASK 4'h6

// ****************************************
// Status bit positions
// ****************************************
`define BIT_COLL 10
`define BIT_GCALL 9
`define BIT_TEN 8
`define BIT_WCOL 7
`define BIT_ROV 6
`define BIT_DA 5
`define BIT_STOP 4

// ****************************************
// Interrupt bit positions
// ****************************************
`define IRQ_W 4
`define IRQ_COLL 0
`define IRQ_WCOL 1
`define IRQ_ROV 2
`define IRQ_STOP 3

`define RST_STATUS 16'h0000
`define RST_OWN_ADDR 10'h000
`define GCALL_ADDR 8'h00
`define TEN_HDR 5'h1e
`endif

// ===== shared/i2c_flags_pkg.sv
// Types shared by the status-flag block
package i2c_flags_pkg;
  typedef struct packed {
    logic coll;
    logic gcall;
    logic ten;
    logic wcol;
    logic rov;
    logic da;
    logic stop;
  } status_flags_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR2 = 3'b010,
    ST_ACK = 3'b011,
    ST_DATA = 3'b100,
    ST_SKIP = 3'b101
  } link_state_t;
endpackage

// ===== verification/i2c_bus_partner.sv
// Bus master model driving the clock and data lines of the shared link
`timescale 1ns/1ps
module i2c_bus_partner (
  input wire logic i_clk,
  output logic o_scl,
  output logic o_sda
);
  // Lines idle high, driven by the model itself; clock stands still between frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic start();
    o_sda <= 1'b1;
    w(4);
    o_scl <= 1'b1;
    w(4);
    o_sda <= 1'b0;
    w(4);
    o_scl <= 1'b0;
  endtask
  task automatic stop();
    o_sda <= 1'b0;
    w(2);
    o_scl <= 1'b1;
    w(4);
    o_sda <= 1'b1;
    w(4);
  endtask
  // Data moves mid-way through the low phase, away from either clock edge
  task automatic send(input logic [7:0] b);
    for (int i = 8; i >= 0; i--) begin
      w(2);
      o_sda <= (i == 0) ? 1'b1 : b[i-1];
      w(2);
      o_scl <= 1'b1;
      w(4);
      o_scl <= 1'b0;
    end
    w(2);
  endtask
endmodule

// ===== verification/i2c_status_flag_logic_checker.sv
// Port assertions of the status-flag block
`timescale 1ns/1ps
`include "i2c_flags_cfg.svh"
module i2c_status_flag_logic_checker (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [`ADDR_W-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic i_sda,
  input wire logic i_master_active,
  input wire logic o_irq,
  input wire logic [7:0] o_tx_data,
  input wire logic o_tx_load
);
  logic tx_seen_r;
  logic mst_seen_r;
  logic low_seen_r;
  logic mask_seen_r;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // ****
  // Causes seen since reset
  // ****
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      tx_seen_r <= 1'b0;
      mst_seen_r <= 1'b0;
      low_seen_r <= 1'b0;
      mask_seen_r <= 1'b0;
    end else begin
      tx_seen_r <= tx_seen_r | (i_wr && i_addr == `OFF_TX_BUF);
      mst_seen_r <= mst_seen_r | i_master_active;
      low_seen_r <= low_seen_r | !i_sda;
      mask_seen_r <= mask_seen_r | (i_wr && i_addr == `OFF_IRQ_MASK && i_wdata[3:0] != 4'h0);
    end
  end
  sequence s_stat_rd;
    (i_rd && i_addr == `OFF_STATUS) ##1 1'b1;
  endsequence
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside read cycle");
  a_unimpl_zero: assert property (s_stat_rd |-> o_rdata[15:11] == 5'h00 && o_rdata[3:0] == 4'h0)
    else $error("unused status bits not zero");
  a_coll_quiet: assert property (s_stat_rd |-> mst_seen_r || !o_rdata[`BIT_COLL])
    else $error("collision flag without master operation");
  a_wcol_quiet: assert property (s_stat_rd |-> tx_seen_r || !o_rdata[`BIT_WCOL])
    else $error("write collision without transmit write");
  a_link_quiet: assert property (s_stat_rd |-> low_seen_r || (o_rdata & 16'h0370) == 16'h0000)
    else $error("link flag set on an idle link");
  a_load_cause: assert property (o_tx_load |-> $past(i_wr) && $past(i_addr) == `OFF_TX_BUF)
    else $error("transmit load without transmit write");
  a_tx_follow: assert property ((i_wr && i_addr == `OFF_TX_BUF) ##1 o_tx_load |-> o_tx_data == $past(i_wdata[7:0]))
    else $error("transmit data differs from written byte");
  a_irq_quiet: assert property (o_irq |-> mask_seen_r)
    else $error("interrupt with every source masked");
endmodule
bind i2c_status_flag_logic i2c_status_flag_logic_checker chk (
  .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sda(i_sda), .i_master_active(i_master_active),
  .o_irq(o_irq), .o_tx_data(o_tx_data), .o_tx_load(o_tx_load)
);

// ===== verification/test_i2c_status_flag_logic.sv
// Self-checking bench of the status-flag block
`timescale 1ns/1ps
`include "i2c_flags_cfg.svh"
module test_i2c_status_flag_logic
  import i2c_flags_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_master_active = 1'b0;
  logic i_master_sda_out = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic [15:0] o_rdata;
  logic o_irq;
  logic o_tx_load;
  logic [7:0] o_tx_data;
  wire scl;
  wire sda;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int loads = 0;
  logic [31:0] rs = 32'hbbf3;
  logic [9:0] own;
  logic [7:0] d0;
  always #25 i_sys_clk = ~i_sys_clk;
  i2c_status_flag_logic dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(scl), .i_sda(sda), .i_master_active(i_master_active),
    .i_master_sda_out(i_master_sda_out), .o_irq(o_irq), .o_tx_data(o_tx_data), .o_tx_load(o_tx_load));
  i2c_bus_partner p (.i_clk(i_sys_clk), .o_scl(scl), .o_sda(sda));
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // Flag order: collision, general call, ten-bit, write collision, overflow, data, stop
  function automatic logic [15:0] st(input logic [6:0] f);
    return {5'h00, f, 4'h0};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m = 16'hffff);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    chk(o_rdata & m, exp & m);
    @(posedge i_sys_clk);
  endtask
  task automatic ic(input logic e);
    @(negedge i_sys_clk);
    chk({15'h0000, o_irq}, {15'h0000, e});
    @(posedge i_sys_clk);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Whole run needs under a thousand cycles
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end
  // Load pulses counted so a rejected write shows up as a missing pulse
  always @(negedge i_sys_clk) begin
    if (o_tx_load === 1'b1) begin
      loads++;
    end
  end
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    rc(`OFF_STATUS, 16'h0000);
    rc(4'hf, 16'h0000);
    $display("end of reset test");
    own = 10'(xs() % 32'd62) + 10'd1;
    d0 = 8'(xs());
    wr(`OFF_OWN_ADDR, {6'h00, own});
    p.start();
    p.send({own[6:0], 1'b0});
    rc(`OFF_STATUS, st(7'b0000000));
    p.send(d0);
    rc(`OFF_STATUS, st(7'b0000010));
    p.send(8'(xs()));
    rc(`OFF_STATUS, st(7'b0000110));
    rc(`OFF_RX_BUF, {8'h00, d0});
    wr(`OFF_STATUS, 16'h0040);
    rc(`OFF_STATUS, st(7'b0000010));
    wr(`OFF_TX_BUF, 16'h00a5);
    rc(`OFF_STATUS, st(7'b0001010));
    wr(`OFF_STATUS, 16'h0080);
    p.stop();
    rc(`OFF_STATUS, st(7'b0000011));
    rc(`OFF_IRQ_STAT, 16'h000e);
    ic(1'b0);
    wr(`OFF_IRQ_MASK, 16'h0008);
    ic(1'b1);
    wr(`OFF_IRQ_STAT, 16'h000f);
    ic(1'b0);
    $display("end of slave receive test");
    p.start();
    rc(`OFF_STATUS, st(7'b0000010));
    p.send(8'h00);
    rc(`OFF_STATUS, st(7'b0100000), 16'hffdf);
    p.stop();
    rc(`OFF_STATUS, st(7'b0000001), 16'hffdf);
    own = 10'(xs()) | 10'h200;
    wr(`OFF_CTRL, 16'h0001);
    wr(`OFF_OWN_ADDR, {6'h00, own});
    p.start();
    p.send({`TEN_HDR, own[9:8], 1'b0});
    p.send(own[7:0]);
    rc(`OFF_STATUS, st(7'b0010000));
    p.stop();
    rc(`OFF_STATUS, st(7'b0000001));
    wr(`OFF_CTRL, 16'h0000);
    // Foreign address: following data must leave flag and buffer alone
    p.start();
    p.send((own[6:0] == 7'h55) ? 8'h54 : 8'haa);
    p.send(8'(xs()));
    p.stop();
    rc(`OFF_STATUS, st(7'b0000001));
    rc(`OFF_RX_BUF, {8'h00, d0});
    $display("end of address test");
    d0 = 8'(xs());
    wr(`OFF_TX_BUF, {8'h00, d0});
    rc(`OFF_STATUS, st(7'b0000001));
    chk({8'h00, o_tx_data}, {8'h00, d0});
    chk(16'(loads), 16'h0001);
    i_master_active <= 1'b1;
    i_master_sda_out <= 1'b1;
    p.start();
    p.send(8'h7f);
    i_master_active <= 1'b0;
    rc(`OFF_STATUS, st(7'b1000000), 16'hfcdf);
    wr(`OFF_IRQ_MASK, 16'h0001);
    ic(1'b1);
    wr(`OFF_STATUS, 16'h0400);
    wr(`OFF_IRQ_STAT, 16'h0001);
    ic(1'b0);
    rc(`OFF_STATUS, 16'h0000, 16'h0400);
    // Master sending low sees the line low: no collision
    i_master_sda_out <= 1'b0;
    i_master_active <= 1'b1;
    p.stop();
    i_master_active <= 1'b0;
    rc(`OFF_STATUS, 16'h0010, 16'h0410);
    $display("end of collision test");
    close_out();
  end
endmodule
